// *** rtl/dial_pulser.sv ***
// Loop-disconnect dial pulser: one digit as a train of break/make pulses.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
module dial_pulser #(
	parameter int PERIOD_CYCLES = modem_strap_pkg::DIAL_PERIOD_CYCLES_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	input wire logic [modem_strap_pkg::DIGIT_W-1:0] digit,
	input wire logic euro,
	output logic line_make,
	output logic busy
);
	import modem_strap_pkg::*;

	localparam logic [31:0] US_MAKE = 32'(PERIOD_CYCLES * US_MAKE_PCT / 100);
	localparam logic [31:0] US_BREAK = 32'(PERIOD_CYCLES * US_BREAK_PCT / 100);
	localparam logic [31:0] EU_MAKE =
		32'(PERIOD_CYCLES * EURO_MAKE_PCT / 100);
	localparam logic [31:0] EU_BREAK =
		32'(PERIOD_CYCLES * EURO_BREAK_PCT / 100);

	dial_state_t state_reg;
	logic [31:0] timer_reg;
	logic [31:0] make_len_reg;
	logic [31:0] break_len_reg;
	logic [DIGIT_W-1:0] pulses_reg;

	// Break first, then make; digit zero sends ten pulses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= DIAL_IDLE;
			timer_reg <= 32'h0000_0000;
			make_len_reg <= 32'h0000_0000;
			break_len_reg <= 32'h0000_0000;
			pulses_reg <= DIGIT_RST;
			line_make <= 1'b1;
			busy <= 1'b0;
		end else begin
			case (state_reg)
			DIAL_IDLE: begin
				if (start) begin
					make_len_reg <= euro ? EU_MAKE : US_MAKE; // see RULE3 RULE4
					break_len_reg <= euro ? EU_BREAK : US_BREAK; // see RULE4
					timer_reg <= (euro ? EU_BREAK : US_BREAK) - 32'h0000_0001;
					pulses_reg <= (digit == 4'h0) ? 4'hA : digit;
					line_make <= 1'b0;
					busy <= 1'b1;
					state_reg <= DIAL_BREAK;
				end
			end
			DIAL_BREAK: begin
				if (timer_reg == 32'h0000_0000) begin
					timer_reg <= make_len_reg - 32'h0000_0001;
					line_make <= 1'b1;
					state_reg <= DIAL_MAKE;
				end else begin
					timer_reg <= timer_reg - 32'h0000_0001;
				end
			end
			DIAL_MAKE: begin
				if (timer_reg != 32'h0000_0000) begin
					timer_reg <= timer_reg - 32'h0000_0001;
				end else if (pulses_reg == 4'h1) begin
					busy <= 1'b0;
					state_reg <= DIAL_IDLE;
				end else begin
					pulses_reg <= pulses_reg - 4'h1;
					timer_reg <= break_len_reg - 32'h0000_0001;
					line_make <= 1'b0;
					state_reg <= DIAL_BREAK;
				end
			end
			default: begin
				state_reg <= DIAL_IDLE;
				line_make <= 1'b1;
				busy <= 1'b0;
			end
			endcase
		end
	end

	// Pulse lengths follow the ratio latched at start
	a_make_ratio: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == DIAL_IDLE && start) |=>
		(make_len_reg == ($past(euro) ? EU_MAKE : US_MAKE)) &&
		(break_len_reg == ($past(euro) ? EU_BREAK : US_BREAK))) // see RULE4
		else $error("dial make/break lengths wrong");
	a_break_first: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == DIAL_IDLE && start) |=> !line_make && busy) // see RULE3
		else $error("dial pulse did not open with a break");
endmodule

// *** rtl/modem_option_strap_control.sv ***
// Option straps, run-time overrides, speed indicator and ring answering
// of a dial modem controller, with an AXI4-Lite register slave.
// Assumes strap and ring pins are asynchronous; command inputs are on aclk.
//
// Functional notes
// RULE1: Protocol strap low selects V.22/V.21; high or open selects 103/212A.
// RULE2: Terminal protocol command overrides the protocol strap at run time.
// RULE3: Dial-ratio strap low uses European make/break timing, else U.S.
// RULE4: U.S. ratio is 40/60 make/break; European is 33/67.
// RULE5: Speed indicator is high in 300 bps mode, low in high speed.
// RULE6: Low speed indicator level means operation at 1200 bps.
// RULE7: Answer-inhibit strap low answers incoming calls on the first ring.
// RULE8: Ring-answer register can enable or disable answering, despite strap.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module modem_option_strap_control #(
	parameter int DIAL_PERIOD_CYCLES = modem_strap_pkg::DIAL_PERIOD_CYCLES_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic protocol_family_strap,
	input wire logic dial_ratio_strap,
	input wire logic answer_inhibit_strap,
	input wire logic ring_detect,
	input wire logic protocol_cmd_valid,
	input wire logic protocol_cmd_bell,
	output logic speed_indicator_n,
	output logic answer_request,
	output logic line_make,
	output logic bell_mode
);
	import modem_strap_pkg::*;

	localparam int PINS = 4;

	logic [PINS-1:0] pin_raw;
	logic [PINS-1:0] pin_meta_reg;
	logic [PINS-1:0] pin_sync_reg;
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [3:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_fire;
	logic [31:0] ctrl_word;
	logic [31:0] ring_word;
	logic [31:0] status_word;
	logic [31:0] ctrl_next;
	logic [31:0] ring_next;
	logic proto_ovr_reg;
	logic proto_bell_reg;
	logic low_speed_reg;
	logic answer_ovr_reg;
	logic [RING_TARGET_W-1:0] ring_target_reg;
	logic [DIGIT_W-1:0] digit_reg;
	logic dial_start_reg;
	logic hangup;
	logic euro_reg;
	logic ring_prev_reg;
	logic ring_rise;
	logic [RING_TARGET_W-1:0] ring_count_reg;
	logic [RING_TARGET_W-1:0] ring_count_next;
	logic auto_en;
	logic [RING_TARGET_W-1:0] target_eff;
	logic bell_mode_next;
	logic dial_busy;

	// Byte-lane merge of a write into an old register word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = data[8*i +: 8];
			end
		end
		return res;
	endfunction

	// Two-stage synchronisers for straps and ring detect
	assign pin_raw = {ring_detect, answer_inhibit_strap, dial_ratio_strap,
		protocol_family_strap};
	for (genvar g = 0; g < PINS; g++) begin : g_sync
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pin_meta_reg[g] <= 1'b1;
				pin_sync_reg[g] <= 1'b1;
			end else begin
				pin_meta_reg[g] <= pin_raw[g];
				pin_sync_reg[g] <= pin_meta_reg[g];
			end
		end
	end

	// Write channel: address and data taken in either order
	assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Status is read-only, so writes to it are errors too
				s_axi_bresp <= (aw_addr_reg == CTRL_ADDR ||
					aw_addr_reg == RING_ANSWER_ADDR) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Register images as software sees them
	always_comb begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[CTRL_PROTO_OVR_BIT] = proto_ovr_reg;
		ctrl_word[CTRL_PROTO_BELL_BIT] = proto_bell_reg;
		ctrl_word[CTRL_LOW_SPEED_BIT] = low_speed_reg;
		ctrl_word[CTRL_DIGIT_LSB +: DIGIT_W] = digit_reg;
		ring_word = 32'h0000_0000;
		ring_word[RING_TARGET_W-1:0] = ring_target_reg;
		ring_word[RING_OVR_BIT] = answer_ovr_reg;
		status_word = 32'h0000_0000;
		status_word[ST_BELL_BIT] = bell_mode;
		status_word[ST_EURO_BIT] = euro_reg;
		status_word[ST_AUTO_BIT] = auto_en;
		status_word[ST_ANSWER_BIT] = answer_request;
		status_word[ST_BUSY_BIT] = dial_busy;
		status_word[ST_LOW_SPEED_BIT] = low_speed_reg;
		status_word[ST_COUNT_LSB +: RING_TARGET_W] = ring_count_reg;
		status_word[ST_PINS_LSB +: PINS] = pin_sync_reg;
	end
	assign ctrl_next = merge(ctrl_word, w_data_reg, w_strb_reg);
	assign ring_next = merge(ring_word, w_data_reg, w_strb_reg);
	assign hangup = wr_fire && aw_addr_reg == CTRL_ADDR &&
		ctrl_next[CTRL_HANGUP_BIT];

	// Control register; a terminal command beats a bus write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			proto_ovr_reg <= 1'b0;
			proto_bell_reg <= 1'b1;
			low_speed_reg <= 1'b0;
			digit_reg <= DIGIT_RST;
			dial_start_reg <= 1'b0;
		end else begin
			dial_start_reg <= wr_fire && aw_addr_reg == CTRL_ADDR &&
				ctrl_next[CTRL_DIAL_BIT] && !dial_busy;
			if (wr_fire && aw_addr_reg == CTRL_ADDR) begin
				proto_ovr_reg <= ctrl_next[CTRL_PROTO_OVR_BIT];
				proto_bell_reg <= ctrl_next[CTRL_PROTO_BELL_BIT];
				low_speed_reg <= ctrl_next[CTRL_LOW_SPEED_BIT];
				digit_reg <= ctrl_next[CTRL_DIGIT_LSB +: DIGIT_W];
			end
			if (protocol_cmd_valid) begin
				proto_ovr_reg <= 1'b1; // see RULE2
				proto_bell_reg <= protocol_cmd_bell; // see RULE2
			end
		end
	end

	// Ring answer register; a write with RING_OVR_BIT set puts software in charge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			answer_ovr_reg <= 1'b0;
			ring_target_reg <= RING_TARGET_RST;
		end else if (wr_fire && aw_addr_reg == RING_ANSWER_ADDR) begin
			answer_ovr_reg <= ring_next[RING_OVR_BIT]; // see RULE8
			ring_target_reg <= ring_next[RING_TARGET_W-1:0]; // see RULE8
		end
	end

	// Protocol family, dial ratio and speed indicator
	always_comb begin
		bell_mode_next = pin_sync_reg[0]; // see RULE1
		if (protocol_cmd_valid) begin
			bell_mode_next = protocol_cmd_bell; // see RULE2
		end else if (proto_ovr_reg) begin
			bell_mode_next = proto_bell_reg; // see RULE2
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bell_mode <= 1'b1;
			euro_reg <= 1'b0;
			speed_indicator_n <= 1'b0;
		end else begin
			bell_mode <= bell_mode_next;
			euro_reg <= !pin_sync_reg[1]; // see RULE3
			// High in 300 bps mode, low in 1200 bps mode
			speed_indicator_n <= low_speed_reg; // see RULE5 RULE6
		end
	end

	// Ring counting and answering; a ring beats a same-cycle hang-up
	assign ring_rise = pin_sync_reg[3] && !ring_prev_reg;
	assign auto_en = answer_ovr_reg ? (ring_target_reg != 8'h00) :
		!pin_sync_reg[2]; // see RULE7 RULE8
	assign target_eff = answer_ovr_reg ? ring_target_reg : 8'h01; // see RULE7
	assign ring_count_next = (hangup ? 8'h00 : ring_count_reg) +
		((ring_rise && ring_count_reg != 8'hFF) ? 8'h01 : 8'h00);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ring_prev_reg <= 1'b1;
			ring_count_reg <= 8'h00;
			answer_request <= 1'b0;
		end else begin
			ring_prev_reg <= pin_sync_reg[3];
			ring_count_reg <= ring_count_next;
			if (ring_rise && auto_en && ring_count_next == target_eff) begin
				answer_request <= 1'b1; // see RULE7 RULE8
			end else if (hangup) begin
				answer_request <= 1'b0;
			end
		end
	end

	// Read channel, one cycle from address to data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr)
			CTRL_ADDR: s_axi_rdata <= ctrl_word;
			RING_ANSWER_ADDR: s_axi_rdata <= ring_word;
			STATUS_ADDR: s_axi_rdata <= status_word;
			default: begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= RESP_SLVERR;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Dial pulser uses the ratio chosen by the strap
	dial_pulser #(
		.PERIOD_CYCLES(DIAL_PERIOD_CYCLES)
	) u_dial (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(dial_start_reg),
		.digit(digit_reg),
		.euro(euro_reg), // see RULE3
		.line_make(line_make),
		.busy(dial_busy)
	);

	a_strap_family: assert property (@(posedge aclk) disable iff (!aresetn)
		(!proto_ovr_reg && !protocol_cmd_valid) |=>
		(bell_mode == $past(pin_sync_reg[0]))) // see RULE1
		else $error("protocol family does not follow strap");
	a_cmd_override: assert property (@(posedge aclk) disable iff (!aresetn)
		protocol_cmd_valid |=> (bell_mode == $past(protocol_cmd_bell)) &&
		proto_ovr_reg) // see RULE2
		else $error("protocol command not applied");
	a_ratio_strap: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 (euro_reg == !$past(pin_sync_reg[1]))) // see RULE3
		else $error("dial ratio does not follow strap");
	a_speed_low: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(low_speed_reg) |-> ##1 speed_indicator_n) // see RULE5
		else $error("speed indicator not high in low speed");
	a_speed_high: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(low_speed_reg) |-> ##1 !speed_indicator_n) // see RULE6
		else $error("speed indicator not low in high speed");
	a_first_ring: assert property (@(posedge aclk) disable iff (!aresetn)
		(!answer_ovr_reg && !pin_sync_reg[2] && ring_rise && !hangup &&
		ring_count_reg == 8'h00) |=> answer_request) // see RULE7
		else $error("no answer on first ring");
	a_sw_disable: assert property (@(posedge aclk) disable iff (!aresetn)
		(answer_ovr_reg && ring_target_reg == 8'h00 && !answer_request) |=>
		!answer_request) // see RULE8
		else $error("answered while disabled by software");
endmodule

// *** rtl/modem_strap_pkg.sv ***
// Constants shared by the option-strap control block and its dial pulser.
// Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus.
package modem_strap_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int DIAL_PERIOD_MS = 100;
	localparam int DIAL_PERIOD_CYCLES_DEF =
		DIAL_PERIOD_MS * 1_000_000 / CLK_PERIOD_NS;
	// Make and break shares of one dial pulse, in percent
	localparam int US_MAKE_PCT = 40;
	localparam int US_BREAK_PCT = 60;
	localparam int EURO_MAKE_PCT = 33;
	localparam int EURO_BREAK_PCT = 67;
	// Line rates, bits per second
	localparam int LOW_SPEED_BPS = 300;
	localparam int HIGH_SPEED_BPS = 1200;
	// Register byte addresses
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] RING_ANSWER_ADDR = 4'h4;
	localparam logic [3:0] STATUS_ADDR = 4'h8;
	// Control register fields
	localparam int CTRL_PROTO_OVR_BIT = 0;
	localparam int CTRL_PROTO_BELL_BIT = 1;
	localparam int CTRL_LOW_SPEED_BIT = 2;
	localparam int CTRL_HANGUP_BIT = 3;
	localparam int CTRL_DIAL_BIT = 4;
	localparam int CTRL_DIGIT_LSB = 8;
	localparam int DIGIT_W = 4;
	// Ring answer register fields
	localparam int RING_TARGET_W = 8;
	localparam int RING_OVR_BIT = 8;
	// Status register fields
	localparam int ST_BELL_BIT = 0;
	localparam int ST_EURO_BIT = 1;
	localparam int ST_AUTO_BIT = 2;
	localparam int ST_ANSWER_BIT = 3;
	localparam int ST_BUSY_BIT = 4;
	localparam int ST_LOW_SPEED_BIT = 5;
	localparam int ST_COUNT_LSB = 8;
	localparam int ST_PINS_LSB = 16;
	// Reset values
	localparam logic [RING_TARGET_W-1:0] RING_TARGET_RST = 8'h00;
	localparam logic [DIGIT_W-1:0] DIGIT_RST = 4'h0;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Dial pulser states
	typedef enum logic [2:0] {
		DIAL_IDLE = 3'b001,
		DIAL_BREAK = 3'b010,
		DIAL_MAKE = 3'b100
	} dial_state_t;
endpackage

// *** testbench/host_terminal.sv ***
// Host terminal model: issues protocol-family commands on aclk.
// Assumes the command parser output is a one-cycle valid pulse.
`timescale 1ns/1ps
module host_terminal (
	input wire logic aclk,
	output logic protocol_cmd_valid,
	output logic protocol_cmd_bell
);
	// Quiet line at time zero
	initial begin
		protocol_cmd_valid = 1'b0;
		protocol_cmd_bell = 1'b0;
	end

	// One-cycle command; payload flipped after so stale bits never match
	task automatic send(input logic bell);
		protocol_cmd_bell <= bell;
		protocol_cmd_valid <= 1'b1;
		@(posedge aclk);
		protocol_cmd_valid <= 1'b0;
		protocol_cmd_bell <= ~bell;
	endtask
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the option-strap control block.
// Assumes the AXI4-Lite slave of the design and a 100 MHz aclk.
`timescale 1ns/1ps
module tb_top;
	import modem_strap_pkg::*;
	localparam int DP = 100;
	logic aclk = 1'b0;
	logic aresetn;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic protocol_family_strap, dial_ratio_strap, answer_inhibit_strap;
	logic ring_detect, protocol_cmd_valid, protocol_cmd_bell;
	logic speed_indicator_n, answer_request, line_make, bell_mode;
	int mismatches = 0;
	int checked = 0;

	// Free-running 100 MHz clock
	always #5 aclk = ~aclk;

	host_terminal host (.aclk, .protocol_cmd_valid, .protocol_cmd_bell);

	modem_option_strap_control #(.DIAL_PERIOD_CYCLES(DP)) uut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .protocol_family_strap,
		.dial_ratio_strap, .answer_inhibit_strap, .ring_detect,
		.protocol_cmd_valid, .protocol_cmd_bell, .speed_indicator_n,
		.answer_request, .line_make, .bell_mode
	);

	// Compare and count; four-state so an unknown never matches
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Write: address and data offered together, each dropped when taken
	// Bready stays up after the answer, so back-to-back calls never
	// assign it twice in one time step
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		chk(s_axi_bresp, er);
	endtask

	// Read: data and response taken at the rvalid edge; rready stays up
	task automatic rd(input logic [3:0] a, input logic [31:0] exp,
		input logic [1:0] er = RESP_OKAY);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		chk(s_axi_rdata, exp);
		chk(s_axi_rresp, er);
	endtask

	// One ring burst, long enough to clear the pin synchroniser
	task automatic ring();
		ring_detect <= 1'b1;
		step(4);
		ring_detect <= 1'b0;
		step(6);
	endtask

	// Dial digit 2 and time the first break and the make between pulses
	task automatic dial(input logic eu, input int brk, input int mk);
		int n, b, m;
		n = 0;
		b = 0;
		m = 0;
		dial_ratio_strap <= ~eu;
		step(4);
		wr(CTRL_ADDR, 32'h0000_0210);
		while (line_make !== 1'b0 && n < 10) begin
			@(posedge aclk);
			n++;
		end
		while (line_make === 1'b0 && b < 500) begin
			@(posedge aclk);
			b++;
		end
		while (line_make === 1'b1 && m < 500) begin
			@(posedge aclk);
			m++;
		end
		chk(b, brk);
		chk(m, mk);
		step(2 * DP);
	endtask

	task automatic give_verdict();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Watchdog: the sequence needs about 10 us; allow ten times that
	initial begin
		#100_000;
		mismatches++;
		give_verdict();
	end

	// Main sequence
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready, ring_detect} = 3'b000;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		protocol_family_strap = 1'b1;
		dial_ratio_strap = 1'b1;
		answer_inhibit_strap = 1'b1;
		step(3);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(speed_indicator_n, 1'b0);
		chk(line_make, 1'b1);
		chk(answer_request, 1'b0);
		rd(CTRL_ADDR, 32'h0000_0002);
		rd(RING_ANSWER_ADDR, 32'h0000_0000);
		step(3);
		chk(bell_mode, 1'b1);
		$display("test reset done");
		protocol_family_strap <= 1'b0;
		step(5);
		chk(bell_mode, 1'b0);
		host.send(1'b1);
		@(posedge aclk);
		chk(bell_mode, 1'b1);
		protocol_family_strap <= 1'b1;
		host.send(1'b0);
		@(posedge aclk);
		chk(bell_mode, 1'b0);
		rd(CTRL_ADDR, 32'h0000_0001);
		wr(CTRL_ADDR, 32'h0000_0000);
		step(2);
		chk(bell_mode, 1'b1);
		$display("test protocol done");
		wr(CTRL_ADDR, 32'h0000_0004);
		step(2);
		chk(speed_indicator_n, 1'b1);
		wr(CTRL_ADDR, 32'h0000_0000);
		step(2);
		chk(speed_indicator_n, 1'b0);
		$display("test speed done");
		dial(1'b0, DP * US_BREAK_PCT / 100, DP * US_MAKE_PCT / 100);
		dial(1'b1, DP * EURO_BREAK_PCT / 100, DP * EURO_MAKE_PCT / 100);
		dial_ratio_strap <= 1'b1;
		$display("test dial done");
		answer_inhibit_strap <= 1'b0;
		step(3);
		ring();
		chk(answer_request, 1'b1);
		wr(CTRL_ADDR, 32'h0000_0008);
		step(2);
		chk(answer_request, 1'b0);
		answer_inhibit_strap <= 1'b1;
		step(3);
		ring();
		chk(answer_request, 1'b0);
		wr(CTRL_ADDR, 32'h0000_0008);
		wr(RING_ANSWER_ADDR, 32'h0000_0102);
		rd(RING_ANSWER_ADDR, 32'h0000_0102);
		ring();
		chk(answer_request, 1'b0);
		ring();
		chk(answer_request, 1'b1);
		wr(CTRL_ADDR, 32'h0000_0008);
		answer_inhibit_strap <= 1'b0;
		wr(RING_ANSWER_ADDR, 32'h0000_0100);
		step(3);
		ring();
		chk(answer_request, 1'b0);
		$display("test answer done");
		wr(4'hC, 32'hFFFF_FFFF, RESP_SLVERR);
		rd(4'hC, 32'h0000_0000, RESP_SLVERR);
		wr(STATUS_ADDR, 32'h0000_0000, RESP_SLVERR);
		rd(RING_ANSWER_ADDR, 32'h0000_0100);
		// Bell on, answering off, one ring counted, pins 0011
		rd(STATUS_ADDR, 32'h0003_0101);
		$display("test refusal done");
		give_verdict();
	end
endmodule
